// [rcm_pkg.sv]
// Purpose: constants for the compatibility configuration block
// Assumes: apb with 32-bit data, byte addresses
// Notes:   address filter module shares this file
`timescale 1ns/1ns
package rcm_pkg;
    localparam logic [7:0]  RCM_OFF_CTRL   = 8'h00;
    localparam logic [7:0]  RCM_OFF_CMD    = 8'h04;
    localparam logic [7:0]  RCM_OFF_STATUS = 8'h08;
    localparam logic [7:0]  RCM_OFF_ADDR   = 8'h0c;
    localparam logic [7:0]  RCM_OFF_GAP    = 8'h10;
    // ctrl fields
    localparam int          RCM_CTRL_TXA   = 0;
    localparam int          RCM_CTRL_RXA   = 1;
    localparam int          RCM_CTRL_FEC   = 2;
    // cmd fields
    localparam int          RCM_CMD_KIND   = 8;
    // status fields
    localparam int          RCM_ST_DONE    = 8;
    localparam int          RCM_ST_OK      = 9;
    localparam int          RCM_ST_REP     = 10;
    localparam int          RCM_ST_FEC     = 11;
    localparam int          RCM_ST_SCR     = 12;
    localparam int          RCM_ST_MOD     = 16;
    // reset values
    localparam logic [15:0] RCM_DEST_RST   = 16'h00ff;
    localparam logic [15:0] RCM_OWN_RST    = 16'h0000;
    localparam logic [15:0] RCM_BCAST      = 16'h00ff;
    localparam logic [4:0]  RCM_OPT_RST    = 5'h00;
    localparam logic [15:0] RCM_GAP_RST    = 16'h0100;
    localparam logic [31:0] RCM_SUPP_RST   = 32'h3ff0013f;
    // repeater arguments, ascii, then the option 3 number
    localparam logic [7:0]  RCM_REP_ON     = 8'h52;
    localparam logic [7:0]  RCM_REP_OFF    = 8'h4f;
    localparam logic [4:0]  RCM_OPT_RXA    = 5'h03;

    typedef enum logic [3:0] {
        RCM_NAT4  = 4'h0,
        RCM_NAT8  = 4'h1,
        RCM_NAT16 = 4'h2,
        RCM_TP4   = 4'h3,
        RCM_TPG   = 4'h4,
        RCM_RXGA  = 4'h5,
        RCM_RXGB  = 4'h6,
        RCM_FST   = 4'h7,
        RCM_VEND  = 4'h8
    } rcm_mod_e;
endpackage

//////////////////////////////////////////////////////////////////////////////
module rcm_addr_filter
    import rcm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic        rx_en,
    input  wire logic        rx_valid,
    input  wire logic [15:0] rx_dest,
    input  wire logic [15:0] own_addr,
    output logic             accept,
    output logic             drop
);
    typedef struct packed {
        logic acc;
        logic drp;
    } rcm_flt_s;

    rcm_flt_s st_r;
    rcm_flt_s st_nxt;
    logic     hit;

    // accept only; no acknowledge or retransmit path exists
    always_comb begin
        hit = !rx_en || rx_dest == own_addr || rx_dest == RCM_BCAST;
        st_nxt = '0;
        st_nxt.acc = rx_valid && hit;
        st_nxt.drp = rx_valid && !hit;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign accept = st_r.acc;
    assign drop   = st_r.drp;

    property p_filter;
        @(posedge clk) disable iff (!rst_b)
        ce && rx_valid && rx_en && rx_dest != own_addr
            && rx_dest != RCM_BCAST |=> !accept && drop;
    endproperty
    a_filter: assert property (p_filter)
        else $error("foreign address accepted");
endmodule

// [rcm_compat_cfg.sv]
// Purpose: compatibility option select, repeater switch and addressing
// Assumes: command words arrive over apb from the serial command parser
// Notes:   modem datapaths sit outside; this block only steers them
//
// Behaviour
// - select command switches the air mode to the numbered option
// - select replies ok when supported, error when not allowed
// - option 0 is default native 4fsk; argument 0 restores it
// - 20: 8fsk fec off, 21: 8fsk fec on, 22: 16fsk fec on
// - 4fsk options 1, 23, 26, 28 fix fec and scrambling
// - gmsk options 2, 24, 27, 29 fix fec and scrambling
// - options 3 and 4 select gmsk reception for two transmitter families
// - fst options 5 and 25; option 8 is a vendor compatible mode
// - destination address used when tx addressing on; resets to 0x00ff
// - own address used when rx addressing on; resets to 0x0000
// - accept only own address or broadcast when rx addressing on
// - repeater available in all modes; argument R on, O off
// - option 3 forces native fec off, restored when mode left
// - native fec setting affects only the native transfer mode
// - all radios of a system share fec and scrambling settings
// - no acknowledge or retransmission in address filtering
// - third-party modes collect whole message, end found by idle gap
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ns
module rcm_compat_cfg
    import rcm_pkg::*;
#(
    parameter logic [31:0] SUPPORTED = RCM_SUPP_RST
)
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ser_byte_valid,
    input  wire logic        rx_valid,
    input  wire logic [15:0] rx_dest,
    output logic [4:0]       compat_option,
    output logic [3:0]       mod_mode,
    output logic             fec_on,
    output logic             scramble_on,
    output logic             repeater_on,
    output logic [15:0]      tx_dest,
    output logic             tx_dest_en,
    output logic             reply_ok,
    output logic             reply_err,
    output logic             msg_ready,
    output logic             rx_accept,
    output logic             rx_drop
);
    typedef struct packed {
        logic [31:0] rdata;
        logic        rdy;
        logic        err;
        logic        txa_en;
        logic        rxa_en;
        logic        nat_fec;
        logic [4:0]  opt;
        logic        rep;
        logic [15:0] dest;
        logic [15:0] own;
        logic [15:0] gap;
        logic [15:0] idle;
        logic        collecting;
        logic        done;
        logic        ok;
        logic        rok;
        logic        rerr;
        logic        mready;
        logic [3:0]  mode;
        logic        fec;
        logic        scr;
        logic [15:0] txd;
        logic        txd_en;
    } rcm_cfg_s;

    rcm_cfg_s st_r;
    rcm_cfg_s st_nxt;

    //////////////////////////////////////////////////////////////////////
    // option decode: {mode, fec, scrambling}; native fec only in option 0
    // fec and scrambling fixed per option except option 0 fec, so peers on any other option agree
    function automatic logic [5:0] decode(input logic [4:0] o,
                                          input logic       nfec);
        case (o)
            5'd0:    decode = {RCM_NAT4, nfec, 1'b0};
            5'd20:   decode = {RCM_NAT8, 2'b00};
            5'd21:   decode = {RCM_NAT8, 2'b10};
            5'd22:   decode = {RCM_NAT16, 2'b10};
            5'd1:    decode = {RCM_TP4, 2'b11};
            5'd23:   decode = {RCM_TP4, 2'b01};
            5'd26:   decode = {RCM_TP4, 2'b00};
            5'd28:   decode = {RCM_TP4, 2'b10};
            5'd2:    decode = {RCM_TPG, 2'b11};
            5'd24:   decode = {RCM_TPG, 2'b01};
            5'd27:   decode = {RCM_TPG, 2'b00};
            5'd29:   decode = {RCM_TPG, 2'b10};
            // native fec forced off here without touching the stored bit
            5'd3:    decode = {RCM_RXGA, 2'b00};
            5'd4:    decode = {RCM_RXGB, 2'b00};
            5'd5:    decode = {RCM_FST, 2'b11};
            5'd25:   decode = {RCM_FST, 2'b01};
            5'd8:    decode = {RCM_VEND, 2'b00};
            default: decode = {RCM_NAT4, 2'b00};
        endcase
    endfunction

    function automatic logic third_party(input logic [4:0] o);
        third_party = !(o == 5'd0 || o == 5'd20 || o == 5'd21
                        || o == 5'd22);
    endfunction

    //////////////////////////////////////////////////////////////////////
    logic       setup;
    logic       wr;
    logic [7:0] arg;
    logic       kind;
    logic [5:0] dec;
    logic       legal;

    always_comb begin
        st_nxt  = st_r;
        setup   = psel && !penable;
        wr      = psel && penable && st_r.rdy && pwrite;
        arg     = pwdata[7:0];
        kind    = pwdata[RCM_CMD_KIND];
        legal   = arg[7:5] == 3'b000 && SUPPORTED[arg[4:0]];
        st_nxt.rok  = 1'b0;
        st_nxt.rerr = 1'b0;
        // read data latched in setup so the answer is one flop deep
        st_nxt.rdy  = setup;
        st_nxt.err  = 1'b0;
        if (setup) begin
            st_nxt.rdata = 32'h0000_0000;
            if (paddr == RCM_OFF_CTRL) begin
                st_nxt.rdata[RCM_CTRL_TXA] = st_r.txa_en;
                st_nxt.rdata[RCM_CTRL_RXA] = st_r.rxa_en;
                st_nxt.rdata[RCM_CTRL_FEC] = st_r.nat_fec;
            end else if (paddr == RCM_OFF_CMD) begin
                st_nxt.rdata = 32'h0000_0000;
            end else if (paddr == RCM_OFF_STATUS) begin
                st_nxt.rdata[4:0]          = st_r.opt;
                st_nxt.rdata[RCM_ST_DONE]  = st_r.done;
                st_nxt.rdata[RCM_ST_OK]    = st_r.ok;
                st_nxt.rdata[RCM_ST_REP]   = st_r.rep;
                st_nxt.rdata[RCM_ST_FEC]   = st_r.fec;
                st_nxt.rdata[RCM_ST_SCR]   = st_r.scr;
                st_nxt.rdata[RCM_ST_MOD+:4] = st_r.mode;
            end else if (paddr == RCM_OFF_ADDR) begin
                st_nxt.rdata = {st_r.own, st_r.dest};
            end else if (paddr == RCM_OFF_GAP) begin
                st_nxt.rdata[15:0] = st_r.gap;
            end else begin
                st_nxt.err = 1'b1;
            end
        end
        if (wr) begin
            if (paddr == RCM_OFF_CTRL) begin
                st_nxt.txa_en  = pwdata[RCM_CTRL_TXA];
                st_nxt.rxa_en  = pwdata[RCM_CTRL_RXA];
                st_nxt.nat_fec = pwdata[RCM_CTRL_FEC];
            end else if (paddr == RCM_OFF_CMD) begin
                st_nxt.done = 1'b1;
                if (!kind) begin
                    if (legal) begin
                        st_nxt.opt = arg[4:0];
                        st_nxt.ok  = 1'b1;
                        st_nxt.rok = 1'b1;
                    end else begin
                        // refused: option untouched
                        st_nxt.ok   = 1'b0;
                        st_nxt.rerr = 1'b1;
                    end
                end else if (arg == RCM_REP_ON || arg == RCM_REP_OFF) begin
                    st_nxt.rep = arg == RCM_REP_ON;
                    st_nxt.ok  = 1'b1;
                    st_nxt.rok = 1'b1;
                end else begin
                    st_nxt.ok   = 1'b0;
                    st_nxt.rerr = 1'b1;
                end
            end else if (paddr == RCM_OFF_ADDR) begin
                st_nxt.dest = pwdata[15:0];
                st_nxt.own  = pwdata[31:16];
            end else if (paddr == RCM_OFF_GAP) begin
                st_nxt.gap = pwdata[15:0];
            end
        end
        dec         = decode(st_r.opt, st_r.nat_fec);
        st_nxt.mode = dec[5:2];
        st_nxt.fec  = dec[1];
        st_nxt.scr  = dec[0];
        // destination goes out only while tx addressing is on
        st_nxt.txd    = st_r.txa_en ? st_r.dest : RCM_BCAST;
        st_nxt.txd_en = st_r.txa_en;
        // message end found by an idle gap on the serial input
        st_nxt.mready = 1'b0;
        if (ser_byte_valid) begin
            st_nxt.idle       = 16'h0000;
            st_nxt.collecting = third_party(st_r.opt);
        end else if (st_r.collecting) begin
            if (st_r.idle >= st_r.gap) begin
                st_nxt.collecting = 1'b0;
                st_nxt.mready     = 1'b1;
            end else begin
                st_nxt.idle = st_r.idle + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r      <= '0;
            st_r.opt  <= RCM_OPT_RST;
            st_r.dest <= RCM_DEST_RST;
            st_r.own  <= RCM_OWN_RST;
            st_r.gap  <= RCM_GAP_RST;
            st_r.txd  <= RCM_BCAST;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // filter uses own address only when rx addressing is on
    rcm_addr_filter u_filt (
        .clk      (clk),
        .rst_b    (rst_b),
        .ce       (ce),
        .rx_en    (st_r.rxa_en),
        .rx_valid (rx_valid),
        .rx_dest  (rx_dest),
        .own_addr (st_r.own),
        .accept   (rx_accept),
        .drop     (rx_drop)
    );

    assign prdata        = st_r.rdata;
    assign pready        = st_r.rdy;
    assign pslverr       = st_r.err;
    assign compat_option = st_r.opt;
    assign mod_mode      = st_r.mode;
    assign fec_on        = st_r.fec;
    assign scramble_on   = st_r.scr;
    assign repeater_on   = st_r.rep;
    assign tx_dest       = st_r.txd;
    assign tx_dest_en    = st_r.txd_en;
    assign reply_ok      = st_r.rok;
    assign reply_err     = st_r.rerr;
    assign msg_ready     = st_r.mready;

    //////////////////////////////////////////////////////////////////////
    logic sel_wr;
    assign sel_wr = ce && wr && paddr == RCM_OFF_CMD && !kind;

    property p_sel_ok;
        @(posedge clk) disable iff (!rst_b)
        sel_wr && legal |=> reply_ok && compat_option == $past(arg[4:0]);
    endproperty
    a_sel_ok: assert property (p_sel_ok)
        else $error("supported option not applied");

    property p_sel_err;
        @(posedge clk) disable iff (!rst_b)
        sel_wr && !legal |=> reply_err && !reply_ok
            && $stable(compat_option);
    endproperty
    a_sel_err: assert property (p_sel_err)
        else $error("refused option changed state");

    property p_opt3_fec;
        @(posedge clk) disable iff (!rst_b)
        ce && compat_option == RCM_OPT_RXA ##1 ce |-> !fec_on;
    endproperty
    a_opt3_fec: assert property (p_opt3_fec)
        else $error("native fec not forced off in option 3");

    property p_native_fec;
        @(posedge clk) disable iff (!rst_b)
        ce && compat_option == 5'd0 && $stable(st_r.nat_fec)
            |=> fec_on == $past(st_r.nat_fec);
    endproperty
    a_native_fec: assert property (p_native_fec)
        else $error("native fec setting not applied");

    property p_opt21;
        @(posedge clk) disable iff (!rst_b)
        ce && compat_option == 5'd21 |=> mod_mode == RCM_NAT8 && fec_on;
    endproperty
    a_opt21: assert property (p_opt21)
        else $error("option 21 decode wrong");

    property p_opt1;
        @(posedge clk) disable iff (!rst_b)
        ce && compat_option == 5'h01
            |=> mod_mode == RCM_TP4 && fec_on && scramble_on;
    endproperty
    a_opt1: assert property (p_opt1)
        else $error("option 1 decode wrong");

    property p_opt25;
        @(posedge clk) disable iff (!rst_b)
        ce && compat_option == 5'h19
            |=> mod_mode == RCM_FST && !fec_on && scramble_on;
    endproperty
    a_opt25: assert property (p_opt25)
        else $error("option 25 decode wrong");

    property p_rx_open;
        @(posedge clk) disable iff (!rst_b)
        ce && rx_valid && !st_r.rxa_en |=> rx_accept && !rx_drop;
    endproperty
    a_rx_open: assert property (p_rx_open)
        else $error("frame dropped with rx addressing off");

    property p_rep;
        @(posedge clk) disable iff (!rst_b)
        ce && wr && paddr == RCM_OFF_CMD && kind && arg == RCM_REP_ON
            |=> repeater_on ##1 repeater_on || !ce || wr;
    endproperty
    a_rep: assert property (p_rep)
        else $error("repeater did not switch on");

    property p_txd;
        @(posedge clk) disable iff (!rst_b)
        ce && st_r.txa_en |=> tx_dest == $past(st_r.dest);
    endproperty
    a_txd: assert property (p_txd)
        else $error("destination address not driven");

    property p_gap;
        @(posedge clk) disable iff (!rst_b)
        msg_ready |-> $past(!ser_byte_valid) && third_party(compat_option);
    endproperty
    a_gap: assert property (p_gap)
        else $error("message end without idle gap");
endmodule

// [rcm_peer_model.sv]
// Purpose: peer radio and serial byte source around the config block
// Assumes: same clock as the block; bytes and frames are one-cycle pulses
// Notes:   rx_dest carries inverted data outside frames, never a stale copy
`timescale 1ns/1ns
module rcm_peer_model #(
    parameter logic [15:0] LOCAL_ADDR = 16'h0005
)
(
    input  wire logic        clk,
    input  wire logic [15:0] tx_dest,
    output logic             ser_byte_valid,
    output logic             rx_valid,
    output logic [15:0]      rx_dest,
    output logic             peer_hit
);
    // peer keeps only messages aimed at its local address
    assign peer_hit = (tx_dest == LOCAL_ADDR);

    initial begin
        ser_byte_valid = 1'b0;
        rx_valid = 1'b0;
        rx_dest = 16'h0000;
    end

    //////////////////////////////////////////////////////////////////////////
    task automatic send_frame(input logic [15:0] d);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_dest <= d;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_dest <= ~d;
    endtask

    task automatic send_bytes(input int n, input int space);
        repeat (n) begin
            @(posedge clk);
            ser_byte_valid <= 1'b1;
            @(posedge clk);
            ser_byte_valid <= 1'b0;
            repeat (space) @(posedge clk);
        end
    endtask
endmodule

// [radio_compat_mode_config_tb.sv]
// Purpose: self-checking bench for the compatibility configuration block
// Assumes: zero-wait apb slave, reply pulses one cycle after the cmd write
// Notes:   ce held high; freeze behaviour is left unexercised
`timescale 1ns/1ns
module radio_compat_mode_config_tb
    import rcm_pkg::*;
;
    localparam logic [15:0] PEER_LOCAL = 16'h0005;
    logic        clk, rst_b, ce, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdq;
    logic        pready, pslverr, rderr, ser_byte_valid, rx_valid, okx;
    logic [15:0] rx_dest, tx_dest, dst, ownv, other;
    logic [4:0]  compat_option;
    logic [3:0]  mod_mode;
    logic [5:0]  e;
    logic        fec_on, scramble_on, repeater_on, tx_dest_en, reply_ok;
    logic        reply_err, msg_ready, rx_accept, rx_drop, peer_hit;
    logic [7:0]  rarg [3] = '{RCM_REP_ON, 8'h41, RCM_REP_OFF};
    logic [2:0]  rok = 3'b101;
    logic [2:0]  rrep = 3'b011;
    int          mismatches, tests_run, cyc, n_ok, n_err, n_acc, n_drop;
    int          n_msg, byte_cyc, msg_cyc, a, cur, seed, gap, m0;
    int          args[$];

    rcm_compat_cfg #(.SUPPORTED(RCM_SUPP_RST)) rcm_compat_cfg_inst (
        .clk(clk), .rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ser_byte_valid(ser_byte_valid),
        .rx_valid(rx_valid), .rx_dest(rx_dest),
        .compat_option(compat_option), .mod_mode(mod_mode),
        .fec_on(fec_on), .scramble_on(scramble_on),
        .repeater_on(repeater_on), .tx_dest(tx_dest),
        .tx_dest_en(tx_dest_en), .reply_ok(reply_ok), .reply_err(reply_err),
        .msg_ready(msg_ready), .rx_accept(rx_accept), .rx_drop(rx_drop));

    rcm_peer_model #(.LOCAL_ADDR(PEER_LOCAL)) rcm_peer_model_inst (
        .clk(clk), .tx_dest(tx_dest), .ser_byte_valid(ser_byte_valid),
        .rx_valid(rx_valid), .rx_dest(rx_dest), .peer_hit(peer_hit));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // pulse monitors, so no check depends on the exact pulse cycle
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (reply_ok === 1'b1) n_ok <= n_ok + 1;
        if (reply_err === 1'b1) n_err <= n_err + 1;
        if (rx_accept === 1'b1) n_acc <= n_acc + 1;
        if (rx_drop === 1'b1) n_drop <= n_drop + 1;
        if (ser_byte_valid === 1'b1) byte_cyc <= cyc;
        if (msg_ready === 1'b1) begin
            n_msg <= n_msg + 1;
            msg_cyc <= cyc;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    function automatic logic [5:0] exp_dec(input int o, input logic nf);
        // {mode, fec, scrambling}
        case (o)
            0: return {RCM_NAT4, nf, 1'b0};
            20: return {RCM_NAT8, 2'b00};
            21: return {RCM_NAT8, 2'b10};
            22: return {RCM_NAT16, 2'b10};
            1: return {RCM_TP4, 2'b11};
            23: return {RCM_TP4, 2'b01};
            26: return {RCM_TP4, 2'b00};
            28: return {RCM_TP4, 2'b10};
            2: return {RCM_TPG, 2'b11};
            24: return {RCM_TPG, 2'b01};
            27: return {RCM_TPG, 2'b00};
            29: return {RCM_TPG, 2'b10};
            3: return {RCM_RXGA, 2'b00};
            4: return {RCM_RXGB, 2'b00};
            5: return {RCM_FST, 2'b11};
            25: return {RCM_FST, 2'b01};
            8: return {RCM_VEND, 2'b00};
            default: return 6'h00;
        endcase
    endfunction

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic apb(input logic wr, input logic [7:0] ad,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            mismatches++;
            $display("ERROR at %0t: no pready", $time);
            wrap_up();
        end
        rdq = prdata;
        rderr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cmd(input logic [31:0] w, input logic ok);
        int o0, e0;
        o0 = n_ok;
        e0 = n_err;
        apb(1'b1, RCM_OFF_CMD, w);
        settle();
        chk(n_ok - o0, 32'(ok));
        chk(n_err - e0, 32'(!ok));
    endtask

    task automatic frame_chk(input logic [15:0] d, input logic acc);
        int a0, d0;
        a0 = n_acc;
        d0 = n_drop;
        rcm_peer_model_inst.send_frame(d);
        settle();
        chk(n_acc - a0, 32'(acc));
        chk(n_drop - d0, 32'(!acc));
    endtask

    //////////////////////////////////////////////////////////////////////////
    initial begin
        #500000;
        mismatches++;
        $display("ERROR at %0t: run timed out", $time);
        wrap_up();
    end

    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        seed = $urandom(38034);
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        settle();
        chk(tx_dest, RCM_DEST_RST);
        chk(compat_option, RCM_OPT_RST);
        chk({mod_mode, fec_on}, {RCM_NAT4, 1'b0});
        apb(1'b0, RCM_OFF_ADDR, 32'h0);
        chk(rdq, {RCM_OWN_RST, RCM_DEST_RST});
        apb(1'b0, 8'h14, 32'h0);
        chk({31'h0, rderr}, 32'h1);
        chk(rdq, 32'h0);
        // native fec on, both addressings off before any option 3
        apb(1'b1, RCM_OFF_CTRL, 32'h4);
        for (int i = 0; i < 34; i++) args.push_back(i);
        args.push_back(3);
        args.push_back(0);
        repeat (8) args.push_back($urandom_range(40, 0));
        cur = 0;
        foreach (args[k]) begin
            a = args[k];
            okx = (a < 32) && RCM_SUPP_RST[a[4:0]];
            cmd(32'(a), okx);
            if (okx) cur = a;
            e = exp_dec(cur, 1'b1);
            chk(compat_option, 32'(cur));
            chk({mod_mode, fec_on, scramble_on}, e);
            chk(fec_on, (cur == 0) || e[1]);
            apb(1'b0, RCM_OFF_STATUS, 32'h0);
            chk(rdq, {12'h0, e[5:2], 3'h0, e[0], e[1], 1'b0, okx, 1'b1,
                      3'h0, 5'(cur)});
        end
        cmd(32'd27, 1'b1);
        for (int i = 0; i < 3; i++) begin
            cmd({23'h0, 1'b1, rarg[i]}, rok[i]);
            chk(repeater_on, rrep[i]);
        end
        ownv = 16'($urandom_range(254, 0));
        other = ownv ^ 16'h0100;
        for (int i = 0; i < 2; i++) begin
            dst = (i == 0) ? PEER_LOCAL : 16'($urandom);
            apb(1'b1, RCM_OFF_ADDR, {ownv, dst});
            apb(1'b1, RCM_OFF_CTRL, 32'h3);
            settle();
            chk({tx_dest_en, tx_dest}, {1'b1, dst});
            chk(peer_hit, dst == PEER_LOCAL);
            frame_chk(ownv, 1'b1);
            frame_chk(RCM_BCAST, 1'b1);
            frame_chk(other, 1'b0);
        end
        apb(1'b1, RCM_OFF_CTRL, 32'h0);
        settle();
        chk({tx_dest_en, tx_dest}, {1'b0, RCM_DEST_RST});
        frame_chk(other, 1'b1);
        // third-party option first, then native, which never waits
        for (int i = 0; i < 2; i++) begin
            gap = $urandom_range(8, 2);
            apb(1'b1, RCM_OFF_GAP, 32'(gap));
            cmd((i == 0) ? 32'd1 : 32'd0, 1'b1);
            m0 = n_msg;
            rcm_peer_model_inst.send_bytes(3, 1);
            repeat (20) @(posedge clk);
            #1;
            chk(n_msg - m0, 32'(i == 0));
            if (i == 0) begin
                chk((msg_cyc - byte_cyc) inside {[gap+1:gap+2]}, 1);
            end
        end
        wrap_up();
    end
endmodule
